// ===== test_usc_core.sv
// Self-checking bench for the SPI-commanded UART core.
`timescale 1ns/1ps
module test_usc_core import usc_pkg::*; ;
	typedef struct packed {
		logic [13:0] cfg;
		logic [15:0] exp;
	} usc_row_t;
	localparam usc_row_t ROWS [4] = '{'{14'h2000, 16'h6000}, '{14'h0CF5, 16'h4CF5},
		'{14'h0308, 16'h4308}, '{14'h0000, 16'h4000}};
	logic mclk, rst_n, cs_n, sclk, serial_in, serial_out, irq_n, tx_line, rx_line, rts_n, cts_n, sleep_state;
	logic [15:0] rsp;
	logic [9:0] txw;
	int failures = 0;
	int comparisons = 0;
	usc_core i_usc_core (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.serial_out(serial_out), .irq_n(irq_n), .tx_line(tx_line), .rx_line(rx_line), .rts_n(rts_n),
		.cts_n(cts_n), .sleep_state(sleep_state));
	usc_host_model i_usc_host_model (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.serial_out(serial_out));
	// Compares one value, counts it and reports a mismatch.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	task automatic xf(input logic [15:0] c);
		i_usc_host_model.xfer(c, rsp);
	endtask : xf
	// Drives one character on the receive line, 16 clocks per bit, low bit first.
	task automatic rx_send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (16) @(posedge mclk);
		end
	endtask : rx_send
	// Waits for a start bit, then samples n bits at their middles.
	task automatic tx_catch(input int bitlen, input int n);
		int k;
		k = 0;
		txw = '0;
		while (tx_line === 1'b1 && k < 2000) begin
			k++;
			@(posedge mclk);
		end
		if (k == 2000) begin
			failures++;
			finish_test();
		end
		repeat (bitlen / 2) @(posedge mclk);
		for (int i = 0; i < n; i++) begin
			repeat (bitlen) @(posedge mclk);
			txw[i] = tx_line;
		end
	endtask : tx_catch
	// Free-running clock at 50 MHz.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Reset, configuration rows, then transmit, receive and shutdown cases.
	initial begin
		int lows;
		int highs;
		rst_n = 1'b0;
		rx_line = 1'b1;
		cts_n = 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		check({12'h000, irq_n, tx_line, rts_n, sleep_state}, 16'h000E);
		xf({CMD_RD_CFG, 14'h0000});
		check(rsp, 16'h4000);
		done("reset");
		foreach (ROWS[r]) begin
			xf({CMD_WR_CFG, ROWS[r].cfg});
			xf({CMD_RD_CFG, 14'h0000});
			check(rsp, ROWS[r].exp);
		end
		done("config rows");
		fork
			xf({CMD_WR_DATA, 14'h0155});
			tx_catch(16, 9);
		join
		check({6'h00, txw}, 16'h0155);
		xf({CMD_WR_DATA, 14'h0655});
		lows = 0;
		repeat (300) begin
			@(posedge mclk);
			if (tx_line !== 1'b1) lows++;
		end
		check({lows[14:0], rts_n}, 16'h0000);
		xf({CMD_WR_DATA, 14'h0400});
		check({15'h0000, rts_n}, 16'h0001);
		xf({CMD_WR_CFG, 14'h0030});
		fork
			xf({CMD_WR_DATA, 14'h01AA});
			tx_catch(16, 9);
		join
		check({6'h00, txw}, 16'h01AA);
		xf({CMD_WR_CFG, 14'h0048});
		fork
			xf({CMD_WR_DATA, 14'h0033});
			tx_catch(48, 10);
		join
		check({6'h00, txw}, 16'h0333);
		done("transmit");
		xf({CMD_WR_CFG, 14'h0400});
		for (int i = 0; i < 9; i++) rx_send(8'h10 + 8'(i));
		check({15'h0000, irq_n}, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			cts_n <= i[0];
			xf({CMD_RD_DATA, 14'h0000});
			check(rsp, {6'h30, !i[0], 9'h010 + 9'(i)});
		end
		xf({CMD_RD_DATA, 14'h0000});
		check({13'h0000, rsp[15:14], irq_n}, 16'h0003);
		xf({CMD_WR_CFG, 14'h0030});
		rx_send(8'hD5);
		xf({CMD_RD_DATA, 14'h0000});
		check({7'h00, rsp[8:0]}, 16'h0155);
		done("receive");
		xf({CMD_WR_CFG, 14'h0001});
		xf({CMD_RD_CFG, 14'h0001});
		check(rsp, 16'h4001);
		fork
			xf({CMD_RD_DATA, 14'h0000});
			begin
				repeat (10) @(posedge mclk);
				lows = 0;
				highs = 0;
				repeat (100) begin
					@(posedge mclk);
					if (rts_n === 1'b0) lows++;
					if (tx_line !== 1'b0) highs++;
				end
			end
		join
		check({lows[7:0], highs[7:0]}, 16'h3200);
		xf({CMD_RD_CFG, 14'h0000});
		check({15'h0000, rts_n}, 16'h0001);
		done("test mode");
		xf({CMD_WR_CFG, 14'h1000});
		xf({CMD_RD_CFG, 14'h0000});
		check({15'h0000, sleep_state}, 16'h0001);
		check(rsp, 16'h5000);
		xf({CMD_WR_CFG, 14'h0000});
		check({15'h0000, sleep_state}, 16'h0000);
		done("shutdown");
		finish_test();
	end
endmodule : test_usc_core

// ===== usc_core.sv
// UART core commanded by 16-bit SPI frames, with rate generator and receive FIFO.
`timescale 1ns/1ps
module usc_core import usc_pkg::*; (
	input wire logic mclk, // Oscillator clock, 50 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic cs_n, // Chip select, active low, synchronous.
	input wire logic sclk, // Shift clock level, sampled on mclk.
	input wire logic serial_in, // Host command bit.
	output logic serial_out, // Reply bit to the host.
	output logic irq_n, // Interrupt request, active low.
	output logic tx_line, // UART transmit line.
	input wire logic rx_line, // UART receive line.
	output logic rts_n, // Request to send, active low.
	input wire logic cts_n, // Clear to send, active low.
	output logic sleep_state // High while in software shutdown.
);
	// ============================================================
	// Shift-clock edge detection and frame shifter
	logic sclk_q, cs_q;
	logic sck_rise, sck_fall, cs_fall, cs_rise;
	logic [4:0] bit_cnt_q;
	logic [15:0] din_q, dout_q;
	logic [15:0] reply;
	logic [1:0] cmd_q;
	logic frame_done;
	assign sck_rise = ~cs_n & sclk & ~sclk_q;
	assign sck_fall = ~cs_n & ~sclk & sclk_q;
	assign cs_fall = ~cs_n & cs_q;
	assign cs_rise = cs_n & ~cs_q;
	assign frame_done = sck_rise && (bit_cnt_q == 5'(FRAME_BITS - 1));

	// Config, UART state and FIFO declarations.
	usc_cfg_t cfg_q, cfg_pend_q;
	logic cfg_pend_v_q;
	logic rts_bit_q, test_q;
	logic tx_idle;
	logic [7:0] tx_buf_q;
	logic tx_par_q, tx_full_q;
	logic [3:0] tick_q;
	logic baud_tick, sixteen_x;
	logic [8:0] div_cnt_q;
	logic [8:0] div_ratio;
	usc_rx_word_t fifo_q [FIFO_DEPTH];
	logic [2:0] rd_ptr_q, wr_ptr_q;
	logic [3:0] count_q;
	logic fe_q, ra_q, rx_q, irq_tx_q;
	logic push, pop;
	usc_rx_word_t rx_word, head;

	// Division ratio from the rate code.
	function automatic logic [8:0] ratio_of(input logic [3:0] code);
		logic [8:0] base;
		base = 9'h001 << code[2:0];
		ratio_of = code[3] ? 9'(base * 2'd3) : base;
	endfunction : ratio_of

	// Reply word for the command held in the top two bits.
	always_comb begin
		head = fifo_q[rd_ptr_q];
		reply = 16'h0000;
		reply[15] = (count_q != 4'h0);
		reply[14] = ~tx_full_q;
		unique case (din_q[1:0])
			CMD_RD_CFG: reply[13:0] = {cfg_q.fifo_disable, sleep_state, cfg_q[11:0]};
			CMD_WR_CFG: reply[13:0] = 14'h0000;
			default: begin
				reply[10] = sleep_state ? ra_q : fe_q;
				reply[9] = ~cts_n;
				reply[8] = head.parity;
				reply[7:0] = {head.data[7] & ~cfg_q.short_word, head.data[6:0]};
			end
		endcase
	end

	// Frame shifter; the status bits load at select fall, the rest of the reply once the command bits are in.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			bit_cnt_q <= 5'h00;
			din_q <= 16'h0000;
			dout_q <= 16'h0000;
			cmd_q <= 2'h0;
		end else begin
			sclk_q <= sclk;
			cs_q <= cs_n;
			if (cs_fall) begin
				bit_cnt_q <= 5'h00;
				din_q <= 16'h0000;
				dout_q <= {reply[15:14], 14'h0000};
			end else if (sck_rise) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
				din_q <= {din_q[14:0], serial_in};
				if (bit_cnt_q == 5'h01) begin
					cmd_q <= {din_q[0], serial_in};
				end
			end else if (sck_fall) begin
				if (bit_cnt_q == 5'h02) begin
					dout_q <= {reply[13:0], 2'b00};
				end else begin
					dout_q <= {dout_q[14:0], 1'b0};
				end
			end
		end
	end
	// The reply bit is the top of the shifter, which moves only after select or shift-clock falls.
	assign serial_out = dout_q[15];

	// ============================================================
	// Configuration and handshake registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= CFG_RESET;
			cfg_pend_q <= CFG_RESET;
			cfg_pend_v_q <= 1'b0;
			rts_bit_q <= 1'b0;
			test_q <= 1'b0;
		end else begin
			if (frame_done && cmd_q == CMD_WR_CFG) begin
				cfg_pend_q <= usc_cfg_t'({din_q[12:0], serial_in});
				cfg_pend_v_q <= 1'b1;
				cfg_q.tx_empty_irq_mask <= din_q[10];
				cfg_q.rx_avail_irq_mask <= din_q[9];
				cfg_q.parity_irq_mask <= din_q[8];
				cfg_q.activity_fault_irq_mask <= din_q[7];
			end else if (cfg_pend_v_q && !tx_full_q && tx_idle) begin
				cfg_q <= cfg_pend_q;
				cfg_pend_v_q <= 1'b0;
			end
			if (frame_done && cmd_q == CMD_WR_DATA) begin
				rts_bit_q <= din_q[8];
			end
			if (frame_done && cmd_q == CMD_RD_CFG) begin
				test_q <= serial_in;
			end
		end
	end
	assign sleep_state = cfg_q.sleep_req;
	assign rts_n = (test_q && !cs_n) ? sixteen_x : ~rts_bit_q;

	// ============================================================
	// Rate generator: divided clock is sixteen times baud.
	assign div_ratio = ratio_of(cfg_q.rate_select);
	assign sixteen_x = (div_cnt_q == 9'h000);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q <= 9'h000;
			tick_q <= 4'h0;
		end else begin
			div_cnt_q <= (div_cnt_q >= div_ratio - 9'h001) ? 9'h000 : div_cnt_q + 9'h001;
			if (sixteen_x) begin
				tick_q <= tick_q + 4'h1;
			end
		end
	end
	assign baud_tick = sixteen_x && (tick_q == OVERSAMPLE);

	// ============================================================
	// Transmitter, fed by a two-entry buffer
	logic [10:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic tx_bit;
	logic [1:0] tb_cnt_q;
	logic [8:0] tb_q [2];
	logic tb_rd_q, tb_wr_q;
	logic tb_in_valid, tb_in_ready, tb_out_valid, tb_out_ready;
	assign tx_idle = (tx_left_q == 4'h0);
	assign tb_in_valid = frame_done && cmd_q == CMD_WR_DATA && !din_q[9] && !sleep_state;
	assign tb_in_ready = (tb_cnt_q != 2'h2);
	assign tb_out_valid = (tb_cnt_q != 2'h0);
	assign tb_out_ready = tx_idle && baud_tick && !cfg_pend_v_q;
	assign tx_full_q = (tb_cnt_q == 2'h2);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tb_cnt_q <= 2'h0;
			tb_rd_q <= 1'b0;
			tb_wr_q <= 1'b0;
			tb_q[0] <= 9'h000;
			tb_q[1] <= 9'h000;
		end else begin
			if (tb_in_valid && tb_in_ready) begin
				tb_q[tb_wr_q] <= {din_q[7], din_q[6:0], serial_in};
				tb_wr_q <= ~tb_wr_q;
			end
			if (tb_out_valid && tb_out_ready) begin
				tb_rd_q <= ~tb_rd_q;
			end
			tb_cnt_q <= tb_cnt_q + 2'((tb_in_valid && tb_in_ready) ? 1 : 0)
				- 2'((tb_out_valid && tb_out_ready) ? 1 : 0);
		end
	end
	// Shift register: start, data, optional parity, stop bits, LSB first.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_q <= 11'h7FF;
			tx_left_q <= 4'h0;
		end else if (tb_out_valid && tb_out_ready) begin
			if (cfg_q.short_word) begin
				tx_sh_q <= cfg_q.parity_on ? {2'b11, tb_q[tb_rd_q][8], tb_q[tb_rd_q][6:0], 1'b0}
					: {3'b111, tb_q[tb_rd_q][6:0], 1'b0};
			end else begin
				tx_sh_q <= cfg_q.parity_on ? {1'b1, tb_q[tb_rd_q][8], tb_q[tb_rd_q][7:0], 1'b0}
					: {2'b11, tb_q[tb_rd_q][7:0], 1'b0};
			end
			tx_left_q <= 4'(9 - (cfg_q.short_word ? 1 : 0) + (cfg_q.parity_on ? 1 : 0)
				+ (cfg_q.extra_halt_bit ? 2 : 1));
		end else if (baud_tick && !tx_idle) begin
			tx_sh_q <= {1'b1, tx_sh_q[10:1]};
			tx_left_q <= tx_left_q - 4'h1;
		end
	end
	// IrDA sends a short high pulse for each zero bit.
	assign tx_bit = tx_idle ? 1'b1 : tx_sh_q[0];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_line <= 1'b1;
		end else if (test_q && !cs_n) begin
			tx_line <= 1'b0;
		end else if (cfg_q.infrared_timing) begin
			tx_line <= ~tx_bit && (tick_q < IRDA_HIGH);
		end else begin
			tx_line <= tx_bit;
		end
	end

	// ============================================================
	// Receiver with mid-bit sampling on the 16x clock
	logic [3:0] rx_ph_q, rx_left_q;
	logic [9:0] rx_sh_q;
	logic rx_busy_q, rx_done, rx_in;
	assign rx_in = cfg_q.infrared_timing ? ~rx_line : rx_line;
	assign rx_done = rx_busy_q && sixteen_x && rx_ph_q == MID_SAMPLE && rx_left_q == 4'h0;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_busy_q <= 1'b0;
			rx_ph_q <= 4'h0;
			rx_left_q <= 4'h0;
			rx_sh_q <= 10'h000;
			fe_q <= 1'b0;
		end else if (sleep_state) begin
			rx_busy_q <= 1'b0;
			fe_q <= 1'b0;
		end else if (sixteen_x) begin
			rx_ph_q <= rx_ph_q + 4'h1;
			if (!rx_busy_q && !rx_in) begin
				rx_busy_q <= 1'b1;
				rx_ph_q <= 4'h0;
				rx_left_q <= 4'(9 - (cfg_q.short_word ? 1 : 0) + (cfg_q.parity_on ? 1 : 0));
			end else if (rx_busy_q && rx_ph_q == MID_SAMPLE) begin
				if (rx_left_q == 4'h0) begin
					rx_busy_q <= 1'b0;
					fe_q <= ~rx_in;
				end else begin
					rx_sh_q <= {rx_in, rx_sh_q[9:1]};
					rx_left_q <= rx_left_q - 4'h1;
				end
			end
		end
	end
	// Align the received bits: data in low bits, parity above.
	always_comb begin
		rx_word = '0;
		unique case ({cfg_q.short_word, cfg_q.parity_on})
			2'b00: rx_word.data = rx_sh_q[9:2];
			2'b01: rx_word = {rx_sh_q[9], rx_sh_q[8:1]};
			2'b10: rx_word.data = {1'b0, rx_sh_q[9:3]};
			default: rx_word = {rx_sh_q[9], 1'b0, rx_sh_q[8:2]};
		endcase
	end

	// ============================================================
	// Receive FIFO, eight deep, oldest first; depth one when disabled.
	assign push = rx_done && rx_in && (count_q < (cfg_q.fifo_disable ? 4'h1 : 4'(FIFO_DEPTH)));
	assign pop = frame_done && (cmd_q == CMD_RD_DATA || cmd_q == CMD_WR_DATA) && count_q != 4'h0;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_q <= 3'h0;
			wr_ptr_q <= 3'h0;
			count_q <= 4'h0;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				fifo_q[i] <= '0;
			end
		end else if (sleep_state || (frame_done && cmd_q == CMD_WR_CFG)) begin
			rd_ptr_q <= 3'h0;
			wr_ptr_q <= 3'h0;
			count_q <= 4'h0;
		end else begin
			if (push) begin
				fifo_q[wr_ptr_q] <= rx_word;
				wr_ptr_q <= wr_ptr_q + 3'h1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
			end
			count_q <= count_q + 4'(push ? 1 : 0) - 4'(pop ? 1 : 0);
		end
	end

	// ============================================================
	// Activity flag and interrupt sources
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ra_q <= 1'b0;
			rx_q <= 1'b1;
			irq_tx_q <= 1'b0;
		end else begin
			rx_q <= rx_line;
			if (!sleep_state) begin
				ra_q <= 1'b0;
			end else if (rx_q != rx_line) begin
				ra_q <= 1'b1;
			end
			// Set wins over the release by a data frame.
			if (tb_out_valid && tb_out_ready && tb_cnt_q == 2'h1) begin
				irq_tx_q <= 1'b1;
			end else if (frame_done && (cmd_q == CMD_RD_DATA || cmd_q == CMD_WR_DATA)) begin
				irq_tx_q <= 1'b0;
			end
		end
	end
	assign irq_n = ~((cfg_q.rx_avail_irq_mask && count_q != 4'h0)
		|| (cfg_q.parity_irq_mask && count_q != 4'h0 && head.parity)
		|| (cfg_q.activity_fault_irq_mask && (sleep_state ? ra_q : fe_q))
		|| (cfg_q.tx_empty_irq_mask && irq_tx_q));
endmodule : usc_core

// ===== usc_core_properties.sv
// Concurrent checks on the ports of the SPI-commanded UART core.
`timescale 1ns/1ps
module usc_core_properties (
	input wire logic mclk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic cs_n, // Chip select.
	input wire logic sclk, // Shift clock.
	input wire logic serial_in, // Command bit.
	input wire logic serial_out, // Reply bit.
	input wire logic irq_n, // Interrupt.
	input wire logic tx_line, // UART out.
	input wire logic rx_line, // UART in.
	input wire logic rts_n, // Request to send.
	input wire logic cts_n, // Clear to send.
	input wire logic sleep_state // Shutdown level.
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// A line level lasts at least three clocks at any rate.
	sequence line_low3;
		!tx_line [*3];
	endsequence
	sequence line_high3;
		tx_line [*3];
	endsequence
	// A shift-clock fall or a select fall within the last two clocks.
	sequence shift_edge;
		$past(sclk) || $past(sclk, 2) || $past(cs_n) || $past(cs_n, 2);
	endsequence
	// Reply bits move only after falls and stand while the shift clock is high.
	reply_hold_a: assert property (!cs_n && $past(!cs_n) && sclk && $past(sclk) |-> $stable(serial_out))
		else $error("reply bit moved while shift clock high");
	reply_shift_a: assert property ($changed(serial_out) && !cs_n |-> !sclk ##0 shift_edge)
		else $error("reply bit moved without a falling edge");
	// The handshake pin moves only through a frame.
	rts_frame_a: assert property ($changed(rts_n) |-> !cs_n || $past(!cs_n))
		else $error("handshake pin moved outside a frame");
	// Line levels on the transmit side are timed by the rate clock.
	start_len_a: assert property ($fell(tx_line) |-> line_low3)
		else $error("transmit low level too short");
	bit_len_a: assert property ($rose(tx_line) |-> line_high3)
		else $error("transmit high level too short");
	// Shutdown waits for an idle line and leaves only through a frame.
	sleep_enter_a: assert property ($rose(sleep_state) |-> tx_line && $past(tx_line))
		else $error("shutdown entered during transmission");
	sleep_exit_a: assert property ($fell(sleep_state) |-> $past(!cs_n) || $past(!cs_n, 2) || $past(!cs_n, 3))
		else $error("shutdown left without a frame");
	sleep_quiet_a: assert property (sleep_state && cs_n |-> tx_line)
		else $error("transmission during shutdown");
endmodule : usc_core_properties

bind usc_core usc_core_properties i_usc_core_properties (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
	.serial_in(serial_in), .serial_out(serial_out), .irq_n(irq_n), .tx_line(tx_line), .rx_line(rx_line),
	.rts_n(rts_n), .cts_n(cts_n), .sleep_state(sleep_state));

// ===== usc_host_model.sv
// SPI host model that sends one 16-bit command frame and collects the reply.
`timescale 1ns/1ps
module usc_host_model (
	input wire logic mclk, // Oscillator clock.
	output logic cs_n, // Chip select, active low.
	output logic sclk, // Shift clock.
	output logic serial_in, // Command bit to the core.
	input wire logic serial_out // Reply bit from the core.
);
	// Idle levels from time zero.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end
	// Waits a number of clock edges.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// One frame, top bit first, four clocks per shift-clock phase.
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
		for (int i = 15; i >= 0; i--) begin
			cs_n <= 1'b0;
			sclk <= 1'b0;
			serial_in <= cmd[i];
			tick(4);
			rsp[i] = serial_out;
			sclk <= 1'b1;
			tick(4);
		end
		sclk <= 1'b0;
		serial_in <= ~cmd[0]; // Released line shows the inverse of the last bit.
		tick(2);
		cs_n <= 1'b1;
		tick(4);
	endtask : xfer
endmodule : usc_host_model

// ===== usc_pkg.sv
// Package of constants and frame layouts for the SPI-commanded UART core.
// ============================================================
// Operation
// - Frame top bits 0,1 returns the stored configuration fields in that frame.
// - Read-config with test bit and select low drives handshake with 16x rate clock.
// - Top reply bit appears at select fall; later bits shift on shift-clock falls.
// - Inhibit set updates only the handshake; inhibit clear transmits the byte.
// - Request-to-send pin low when handshake bit is one, high when zero.
// - Parity on sends parity equal to tx_parity_value; off sends no parity bit.
// - Seven-bit mode ignores transmit bit 7 and returns received bit 7 as zero.
// - Every reply carries receive-ready in bit 15 and transmit-buffer-not-full in bit 14.
// - Data replies carry inverted clear-to-send pin level in bit 9.
// - Data replies carry the received parity bit in bit 8.
// - Data reply bit 10 is receive activity in shutdown, framing error otherwise.
// - Read-data frame is all zeros; reply holds status, zeros, flags and byte.
// - Rate codes 0-7 divide by 1..128, codes 8-15 divide by 3..384.
// - The divided rate clock is sixteen times baud and times both directions.
// - Read-data or write-data frame releases interrupt unless a cause still holds.
// - Received characters wait in an eight-word FIFO, oldest first.
// - Entering software shutdown empties the receive FIFO.
// - FIFO enabled at power-up; fifo_disable written sets it; read back reports it.
// - extra_halt_bit selects two stop bits; infrared_timing selects IrDA pulses.
// - short_word selects seven data bits; parity adds one bit both ways.
// - Parity and activity/fault masks enable their interrupt sources.
// - Masks apply after the sixteenth shift edge; other fields after transmission ends.
// - Interrupt stays asserted while receive-ready and its mask are both set.
// ============================================================
package usc_pkg;
	localparam logic [1:0] CMD_RD_DATA = 2'h0;
	localparam logic [1:0] CMD_RD_CFG = 2'h1;
	localparam logic [1:0] CMD_WR_DATA = 2'h2;
	localparam logic [1:0] CMD_WR_CFG = 2'h3;
	localparam int FRAME_BITS = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] RATE_RESET = 4'h0;
	localparam logic [3:0] OVERSAMPLE = 4'hF;
	localparam logic [3:0] IRDA_HIGH = 4'h3;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	// Configuration fields as stored, in frame order from bit 13 down.
	typedef struct packed {
		logic fifo_disable;
		logic sleep_req;
		logic tx_empty_irq_mask;
		logic rx_avail_irq_mask;
		logic parity_irq_mask;
		logic activity_fault_irq_mask;
		logic infrared_timing;
		logic extra_halt_bit;
		logic parity_on;
		logic short_word;
		logic [3:0] rate_select;
	} usc_cfg_t;
	localparam usc_cfg_t CFG_RESET = usc_cfg_t'(14'h0000);
	// One received character with its parity bit.
	typedef struct packed {
		logic parity;
		logic [7:0] data;
	} usc_rx_word_t;
endpackage : usc_pkg
